// ==== design/ssp_map.vh ====
/*
  Constants for the synthesizer serial program port: word layout,
  addresses, field positions, reset values and postscaler codes.
  Assumes it is included by bare name after `timescale in each file.
*/
// Notes on behaviour
// - 24-bit words arrive LSB first on serial clock.
// - Strobe rising edge commits holding word by address.
// - Each word commits alone; others stay unchanged.
// - Main word commit starts main speed-up interval.
// - Bits 23:22 address; 00 main, 01/10 aux, 11 device.
// - Main word: swallow 5, count 11, duration 6.
// - Aux-1 word: swallow, count, main ratio, shared duration.
// - Aux-2 word: swallow, count, aux ratio, three postscalers.
// - Device word: ref divider, enables, lock select, test.
// - Main divides by 32 times count plus swallow.
// - Main speed-up lasts twice duration postscaled reference periods.
// - Aux-1 divides by 8 times count plus swallow.
// - Aux speed-up lasts twice shared duration periods.
// - Each aux loop has its own speed-up counter.
// - Aux-2 divides by 8 times count plus swallow.
// - Postscaler codes divide reference by 1, 2, 4, 8.
// - Reference counter divides oscillator by divider value.
// - Section powered while its enable bit is one.
// - Main value and aux enables apply on reference pulse.
// - Aux speed-up starts only on enable zero-to-one.
// - Speed-up counters count down, release at zero.
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
`define SSP_WORD_W     24
`define SSP_ADDR       23:22
`define SSP_DATA       21:0
`define SSP_ADDR_MAIN  2'h0
`define SSP_ADDR_AUX1  2'h1
`define SSP_ADDR_AUX2  2'h2
`define SSP_ADDR_DEV   2'h3
`define SSP_MAIN_DUR   21:16
`define SSP_MAIN_CNT   15:5
`define SSP_MAIN_SWL   4:0
`define SSP_AUX_DUR    21:16
`define SSP_AUX_RATIO  15:14
`define SSP_AUX_CNT    13:3
`define SSP_AUX_SWL    2:0
`define SSP_POST_AUX2  21:20
`define SSP_POST_AUX1  19:18
`define SSP_POST_MAIN  17:16
`define SSP_DEV_TEST   21:16
`define SSP_DEV_LOCK   15:14
`define SSP_DEV_PWR_A2 13
`define SSP_DEV_PWR_A1 12
`define SSP_DEV_PWR_M  11
`define SSP_DEV_REFDIV 10:0
`define SSP_MAIN_CONTIG 11'h01f
`define SSP_AUX_CONTIG  11'h007
`define SSP_RST_REFDIV  11'h001
`define SSP_POST_DIV1  2'h0
`define SSP_POST_DIV2  2'h1
`define SSP_POST_DIV4  2'h2
`define SSP_POST_DIV8  2'h3
`define SSP_POST_LIM1  3'h0
`define SSP_POST_LIM2  3'h1
`define SSP_POST_LIM4  3'h3
`define SSP_POST_LIM8  3'h7
`endif

// ==== design/ssp_postscale.v ====
/*
  Reference postscaler: passes every 1st, 2nd, 4th or 8th tick.
  Assumes tick_in is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_map.vh"
module ssp_postscale (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       tick_in,
  input  wire [1:0] sel_in,
  output reg        pulse_out
);
  reg [2:0] cnt;
  reg [2:0] limit;

  // Select decode to terminal count
  always @* begin
    case (sel_in)
      `SSP_POST_DIV1: limit = `SSP_POST_LIM1;
      `SSP_POST_DIV2: limit = `SSP_POST_LIM2;
      `SSP_POST_DIV4: limit = `SSP_POST_LIM4;
      default:        limit = `SSP_POST_LIM8;
    endcase
  end

  // Count ticks; a shrinking select wraps at once, never stalls
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt       <= 3'h0;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= 1'b0;
      if (tick_in) begin
        if (cnt >= limit) begin
          cnt       <= 3'h0;
          pulse_out <= 1'b1;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/ssp_speedup.v ====
/*
  Speed-up down-counter for one loop: loaded with twice the duration,
  counts phase-detector reference ticks, active until zero.
  Assumes load_in and tick_in are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_map.vh"
module ssp_speedup #(
  parameter W = 7
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         enable_in,
  input  wire         load_in,
  input  wire [W-1:0] load_value_in,
  input  wire         tick_in,
  output reg          active_out
);
  reg [W-1:0] count;
  reg [W-1:0] next_count;

  // Powered-down section holds no speed-up state
  always @* begin
    next_count = count;
    if (!enable_in)
      next_count = {W{1'b0}};
    else if (load_in)
      next_count = load_value_in;
    else if (tick_in && (count != {W{1'b0}}))
      next_count = count - {{(W-1){1'b0}}, 1'b1};
  end

  // Active flag registered so it is glitch free
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count      <= {W{1'b0}};
      active_out <= 1'b0;
    end else begin
      count      <= next_count;
      active_out <= (next_count != {W{1'b0}});
    end
  end
endmodule
`default_nettype wire

// ==== design/ssp_serial_port.v ====
/*
  Serial program port and control-word bank of a triple synthesizer:
  shift register, strobe commit, reference divider, postscalers and
  speed-up counters. Assumes serial pins and the reference oscillator
  are asynchronous and far slower than the 50 MHz system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_map.vh"
module ssp_serial_port (
  // System clock and asynchronous reset
  input  wire        CLK_SYS_IN,
  input  wire        SYS_RST_IN,
  // Serial link and reference oscillator pins, all asynchronous
  input  wire        SER_CLK_IN,
  input  wire        SER_DATA_IN,
  input  wire        SER_STROBE_IN,
  input  wire        REF_OSC_IN,
  // Applied divider totals and contiguity flags
  output reg  [15:0] MAIN_DIVIDE_OUT,
  output reg         MAIN_CONTIG_OUT,
  output reg  [13:0] AUX1_DIVIDE_OUT,
  output reg         AUX1_CONTIG_OUT,
  output reg  [13:0] AUX2_DIVIDE_OUT,
  output reg         AUX2_CONTIG_OUT,
  // Current ratios and postscaler selects
  output reg  [1:0]  MAIN_RATIO_OUT,
  output reg  [1:0]  AUX_RATIO_OUT,
  output reg  [1:0]  MAIN_POST_OUT,
  output reg  [1:0]  AUX1_POST_OUT,
  output reg  [1:0]  AUX2_POST_OUT,
  // Device-wide fields
  output reg  [10:0] REF_DIVIDE_OUT,
  output reg         MAIN_POWER_OUT,
  output reg         AUX1_POWER_OUT,
  output reg         AUX2_POWER_OUT,
  output reg  [1:0]  LOCK_SEL_OUT,
  output reg  [5:0]  TEST_FIELD_OUT,
  // Reference pulses and speed-up levels
  output reg         REF_TICK_OUT,
  output wire        MAIN_PD_REF_OUT,
  output wire        AUX1_PD_REF_OUT,
  output wire        AUX2_PD_REF_OUT,
  output wire        MAIN_SPEEDUP_OUT,
  output wire        AUX1_SPEEDUP_OUT,
  output wire        AUX2_SPEEDUP_OUT
);
  // Pin positions in the synchroniser vectors
  localparam SCK = 0;
  localparam SDA = 1;
  localparam STB = 2;
  localparam OSC = 3;

  // Divide total: main modulus is 32, so the sum is a concatenation
  function [15:0] main_total;
    input [10:0] cnt;
    input [4:0]  swl;
    begin
      main_total = {cnt, swl};
    end
  endfunction

  // Divide total: aux modulus is 8, used by both auxiliary loops
  function [13:0] aux_total;
    input [10:0] cnt;
    input [2:0]  swl;
    begin
      aux_total = {cnt, swl};
    end
  endfunction

  // Contiguity test: main needs a count of at least 31
  function main_contig;
    input [10:0] cnt;
    begin
      main_contig = (cnt >= `SSP_MAIN_CONTIG);
    end
  endfunction

  // Contiguity test shared by both auxiliary loops
  function aux_contig;
    input [10:0] cnt;
    begin
      aux_contig = (cnt >= `SSP_AUX_CONTIG);
    end
  endfunction

  // Speed-up start: applied enable low, pending enable high
  function enable_step;
    input applied;
    input pending;
    begin
      enable_step = ~applied & pending;
    end
  endfunction

  // Synchroniser stages and holding register
  reg  [3:0]  meta;
  reg  [3:0]  sync;
  reg  [3:0]  sync_d;
  reg  [23:0] hold;

  // Words waiting for a reference pulse
  reg  [21:0] main_pend;
  reg         main_pend_vld;
  reg  [21:0] dev_pend;
  reg         dev_pend_vld;

  // Applied durations, speed-up load pulses and reference count
  reg  [5:0]  main_dur;
  reg  [5:0]  aux_dur;
  reg         main_load;
  reg         aux1_load;
  reg         aux2_load;
  reg  [10:0] ref_cnt;

  // Decoded events
  wire        sck_rise;
  wire        stb_rise;
  wire        osc_rise;
  wire [1:0]  addr;
  wire        ref_tick;

  // Two-stage synchronisers plus a delayed copy for edge detection; the first stage is never looked at
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      meta   <= 4'h0;
      sync   <= 4'h0;
      sync_d <= 4'h0;
    end else begin
      meta   <= {REF_OSC_IN, SER_STROBE_IN, SER_DATA_IN, SER_CLK_IN};
      sync   <= meta;
      sync_d <= sync;
    end
  end

  // Edge detectors on the synchronised copies
  assign sck_rise = sync[SCK] & ~sync_d[SCK];
  assign stb_rise = sync[STB] & ~sync_d[STB];
  assign osc_rise = sync[OSC] & ~sync_d[OSC];
  assign addr     = hold[`SSP_ADDR];

  // Holding register, LSB first: new bits enter at the top
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      hold <= 24'h000000;
    end else if (sck_rise) begin
      hold <= {sync[SDA], hold[23:1]};
    end
  end

  // Aux words act at once; their loops only matter when powered
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      AUX1_DIVIDE_OUT <= 14'h0000;
      AUX1_CONTIG_OUT <= 1'b0;
      AUX2_DIVIDE_OUT <= 14'h0000;
      AUX2_CONTIG_OUT <= 1'b0;
      MAIN_RATIO_OUT  <= 2'h0;
      AUX_RATIO_OUT   <= 2'h0;
      MAIN_POST_OUT   <= `SSP_POST_DIV1;
      AUX1_POST_OUT   <= `SSP_POST_DIV1;
      AUX2_POST_OUT   <= `SSP_POST_DIV1;
      aux_dur         <= 6'h00;
    end else if (stb_rise) begin
      // Auxiliary-1 word: coefficients, main ratio, shared duration
      if (addr == `SSP_ADDR_AUX1) begin
        AUX1_DIVIDE_OUT <= aux_total(hold[`SSP_AUX_CNT],
                                     hold[`SSP_AUX_SWL]);
        AUX1_CONTIG_OUT <= aux_contig(hold[`SSP_AUX_CNT]);
        MAIN_RATIO_OUT  <= hold[`SSP_AUX_RATIO];
        aux_dur         <= hold[`SSP_AUX_DUR];
      end
      // Auxiliary-2 word: coefficients, aux ratio, postscalers
      if (addr == `SSP_ADDR_AUX2) begin
        AUX2_DIVIDE_OUT <= aux_total(hold[`SSP_AUX_CNT],
                                     hold[`SSP_AUX_SWL]);
        AUX2_CONTIG_OUT <= aux_contig(hold[`SSP_AUX_CNT]);
        AUX_RATIO_OUT   <= hold[`SSP_AUX_RATIO];
        MAIN_POST_OUT   <= hold[`SSP_POST_MAIN];
        AUX1_POST_OUT   <= hold[`SSP_POST_AUX1];
        AUX2_POST_OUT   <= hold[`SSP_POST_AUX2];
      end
    end
  end

  // Main and device words wait for a reference pulse; a new
  // commit in the apply cycle stays pending, so none is lost
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      main_pend     <= 22'h000000;
      main_pend_vld <= 1'b0;
      dev_pend      <= 22'h000000;
      dev_pend_vld  <= 1'b0;
    end else begin
      // Main word pending
      if (stb_rise && addr == `SSP_ADDR_MAIN) begin
        main_pend     <= hold[`SSP_DATA];
        main_pend_vld <= 1'b1;
      end else if (ref_tick) begin
        main_pend_vld <= 1'b0;
      end
      // Device word pending
      if (stb_rise && addr == `SSP_ADDR_DEV) begin
        dev_pend     <= hold[`SSP_DATA];
        dev_pend_vld <= 1'b1;
      end else if (ref_tick) begin
        dev_pend_vld <= 1'b0;
      end
    end
  end

  // Apply main word on the reference pulse, then fire speed-up
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      MAIN_DIVIDE_OUT <= 16'h0000;
      MAIN_CONTIG_OUT <= 1'b0;
      main_dur        <= 6'h00;
      main_load       <= 1'b0;
    end else begin
      main_load <= 1'b0;
      if (ref_tick && main_pend_vld) begin
        MAIN_DIVIDE_OUT <= main_total(main_pend[`SSP_MAIN_CNT],
                                      main_pend[`SSP_MAIN_SWL]);
        MAIN_CONTIG_OUT <= main_contig(main_pend[`SSP_MAIN_CNT]);
        main_dur        <= main_pend[`SSP_MAIN_DUR];
        main_load       <= 1'b1;
      end
    end
  end

  // Apply device word on the reference pulse
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REF_DIVIDE_OUT <= `SSP_RST_REFDIV;
      MAIN_POWER_OUT <= 1'b0;
      AUX1_POWER_OUT <= 1'b0;
      AUX2_POWER_OUT <= 1'b0;
      LOCK_SEL_OUT   <= 2'h0;
      TEST_FIELD_OUT <= 6'h00;
    end else if (ref_tick && dev_pend_vld) begin
      REF_DIVIDE_OUT <= dev_pend[`SSP_DEV_REFDIV];
      MAIN_POWER_OUT <= dev_pend[`SSP_DEV_PWR_M];
      AUX1_POWER_OUT <= dev_pend[`SSP_DEV_PWR_A1];
      AUX2_POWER_OUT <= dev_pend[`SSP_DEV_PWR_A2];
      LOCK_SEL_OUT   <= dev_pend[`SSP_DEV_LOCK];
      TEST_FIELD_OUT <= dev_pend[`SSP_DEV_TEST];
    end
  end

  // Aux speed-up only on a zero-to-one enable step at apply time;
  // registered like the main load, so the detector pulse of the
  // applying tick is not counted and the interval is full length
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aux1_load <= 1'b0;
      aux2_load <= 1'b0;
    end else begin
      aux1_load <= ref_tick & dev_pend_vld
                 & enable_step(AUX1_POWER_OUT, dev_pend[`SSP_DEV_PWR_A1]);
      aux2_load <= ref_tick & dev_pend_vld
                 & enable_step(AUX2_POWER_OUT, dev_pend[`SSP_DEV_PWR_A2]);
    end
  end

  // Reference counter on oscillator rising edges; value 0 acts as 2048
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ref_cnt      <= 11'h000;
      REF_TICK_OUT <= 1'b0;
    end else begin
      REF_TICK_OUT <= 1'b0;
      if (osc_rise) begin
        if (ref_cnt >= REF_DIVIDE_OUT - 11'h001) begin
          ref_cnt      <= 11'h000;
          REF_TICK_OUT <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 11'h001;
        end
      end
    end
  end

  // Internal name for the registered reference pulse
  assign ref_tick = REF_TICK_OUT;

  // One postscaler per loop
  ssp_postscale u_post_main (
    .clk_in    (CLK_SYS_IN),
    .rst_in    (SYS_RST_IN),
    .tick_in   (ref_tick),
    .sel_in    (MAIN_POST_OUT),
    .pulse_out (MAIN_PD_REF_OUT)
  );

  ssp_postscale u_post_aux1 (
    .clk_in    (CLK_SYS_IN),
    .rst_in    (SYS_RST_IN),
    .tick_in   (ref_tick),
    .sel_in    (AUX1_POST_OUT),
    .pulse_out (AUX1_PD_REF_OUT)
  );

  ssp_postscale u_post_aux2 (
    .clk_in    (CLK_SYS_IN),
    .rst_in    (SYS_RST_IN),
    .tick_in   (ref_tick),
    .sel_in    (AUX2_POST_OUT),
    .pulse_out (AUX2_PD_REF_OUT)
  );

  // Main speed-up needs main power applied by the same reference pulse or earlier
  ssp_speedup #(.W(7)) u_spd_main (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .enable_in     (MAIN_POWER_OUT),
    .load_in       (main_load),
    .load_value_in ({main_dur, 1'b0}),
    .tick_in       (MAIN_PD_REF_OUT),
    .active_out    (MAIN_SPEEDUP_OUT)
  );

  // Shared duration, separate counters per aux loop
  ssp_speedup #(.W(7)) u_spd_aux1 (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .enable_in     (AUX1_POWER_OUT),
    .load_in       (aux1_load),
    .load_value_in ({aux_dur, 1'b0}),
    .tick_in       (AUX1_PD_REF_OUT),
    .active_out    (AUX1_SPEEDUP_OUT)
  );

  ssp_speedup #(.W(7)) u_spd_aux2 (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .enable_in     (AUX2_POWER_OUT),
    .load_in       (aux2_load),
    .load_value_in ({aux_dur, 1'b0}),
    .tick_in       (AUX2_PD_REF_OUT),
    .active_out    (AUX2_SPEEDUP_OUT)
  );
endmodule
`default_nettype wire

// ==== test/ssp_checker.sv ====
/*
  Checker for the serial program port: when applied words may change,
  contiguity flags, reference pulses and speed-up intervals.
  Assumes it is bound to ssp_serial_port and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_checker (
  input wire logic        CLK_SYS_IN,
  input wire logic        SYS_RST_IN,
  input wire logic        REF_TICK_OUT,
  input wire logic [15:0] MAIN_DIVIDE_OUT,
  input wire logic        MAIN_CONTIG_OUT,
  input wire logic [13:0] AUX1_DIVIDE_OUT,
  input wire logic        AUX1_CONTIG_OUT,
  input wire logic [10:0] REF_DIVIDE_OUT,
  input wire logic        MAIN_POWER_OUT,
  input wire logic        AUX1_POWER_OUT,
  input wire logic        MAIN_PD_REF_OUT,
  input wire logic        AUX1_PD_REF_OUT,
  input wire logic        MAIN_SPEEDUP_OUT,
  input wire logic        AUX1_SPEEDUP_OUT
);
  // One clock domain, reset disables everything
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // Reference and postscaler pulses
  chk_tick_pulse: assert property (REF_TICK_OUT |=> !REF_TICK_OUT)
    else $error("reference tick wider than one cycle");
  chk_pd_after_tick: assert property ((MAIN_PD_REF_OUT || AUX1_PD_REF_OUT) |-> $past(REF_TICK_OUT))
    else $error("detector reference pulse without a tick");
  // Main and device words only change on a reference pulse
  chk_main_on_tick: assert property (!$stable(MAIN_DIVIDE_OUT) |-> $past(REF_TICK_OUT))
    else $error("main divide changed off a tick");
  chk_dev_on_tick: assert property (!$stable({REF_DIVIDE_OUT, MAIN_POWER_OUT, AUX1_POWER_OUT})
    |-> $past(REF_TICK_OUT))
    else $error("device word changed off a tick");
  // Contiguity follows the applied count
  chk_main_contig: assert property (MAIN_CONTIG_OUT == (MAIN_DIVIDE_OUT[15:5] >= 11'h01f))
    else $error("main contiguity flag wrong");
  chk_aux_contig: assert property (AUX1_CONTIG_OUT == (AUX1_DIVIDE_OUT[13:3] >= 11'h007))
    else $error("aux contiguity flag wrong");
  // Speed-up starts and ends
  chk_aux_start: assert property ($rose(AUX1_SPEEDUP_OUT) |-> AUX1_POWER_OUT && !$past(AUX1_POWER_OUT, 2))
    else $error("aux speed-up without enable rise");
  chk_main_start: assert property ($rose(MAIN_SPEEDUP_OUT) |-> $past(REF_TICK_OUT, 2) && MAIN_POWER_OUT)
    else $error("main speed-up start mistimed");
  chk_main_end: assert property ($fell(MAIN_SPEEDUP_OUT) |-> $past(MAIN_PD_REF_OUT) || !MAIN_POWER_OUT)
    else $error("main speed-up ended off a pulse");
  chk_aux_end: assert property ($fell(AUX1_SPEEDUP_OUT) |-> $past(AUX1_PD_REF_OUT) || !AUX1_POWER_OUT)
    else $error("aux speed-up ended off a pulse");

  cov_aux_speedup: cover property ($rose(AUX1_SPEEDUP_OUT));
  cov_main_speedup: cover property ($fell(MAIN_SPEEDUP_OUT));
  cov_main_apply: cover property (MAIN_CONTIG_OUT && !$stable(MAIN_DIVIDE_OUT));
endmodule
bind ssp_serial_port ssp_checker i_chk (.*);
`default_nettype wire

// ==== test/ssp_host_model.sv ====
/*
  Host controller model: shifts 24-bit words bit 0 first, then strobes.
  Assumes a free-running system clock; drives just after its rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_host_model (
  input  wire logic clk_in,
  output var  logic ser_clk_out,
  output var  logic ser_data_out,
  output var  logic ser_strobe_out
);
  int hcyc = 4; // Half link period in system cycles, raise for a slow host
  // Link starts low; clock and strobe idle low outside frames
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_strobe_out = 1'b0;
  end
  task automatic half;
    repeat (hcyc) @(posedge clk_in);
  endtask
  // Data settles a half period before each rise and holds a half after
  task automatic send_word(input logic [23:0] w, input logic commit);
    for (int i = 0; i < 24; i++) begin
      ser_data_out <= w[i];
      half();
      ser_clk_out <= 1'b1;
      half();
      ser_clk_out <= 1'b0;
    end
    half();
    ser_data_out <= ~w[23]; // Released line never shows a stale bit
    ser_strobe_out <= commit;
    half();
    half();
    ser_strobe_out <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
/*
  Self-checking bench for the serial program port: host model on the
  link, reference oscillator at 160 ns, results judged at the outputs.
  Assumes the checker is bound to the port module.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic              clk;
  logic              rst = 1'b1;
  logic              osc = 1'b0;
  wire logic         s_clk, s_dat, s_stb, tick;
  wire logic [15:0]  m_div;
  wire logic [13:0]  a1_div, a2_div;
  wire logic [10:0]  r_div;
  wire logic [5:0]   test;
  wire logic [1:0]   m_rat, a_rat, m_post, a1_post, a2_post, lock;
  wire logic         m_ctg, a1_ctg, a2_ctg, m_pwr, a1_pwr, a2_pwr;
  wire logic         m_pd, a1_pd, a2_pd, m_spd, a1_spd, a2_spd;
  int                error_cnt = 0;
  int                check_count = 0;
  int                cyc = 0;

  ssp_host_model i_host (.clk_in(clk), .ser_clk_out(s_clk), .ser_data_out(s_dat),
    .ser_strobe_out(s_stb));
  ssp_serial_port i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .SER_CLK_IN(s_clk),
    .SER_DATA_IN(s_dat), .SER_STROBE_IN(s_stb), .REF_OSC_IN(osc), .MAIN_DIVIDE_OUT(m_div),
    .MAIN_CONTIG_OUT(m_ctg), .AUX1_DIVIDE_OUT(a1_div), .AUX1_CONTIG_OUT(a1_ctg),
    .AUX2_DIVIDE_OUT(a2_div), .AUX2_CONTIG_OUT(a2_ctg), .MAIN_RATIO_OUT(m_rat),
    .AUX_RATIO_OUT(a_rat), .MAIN_POST_OUT(m_post), .AUX1_POST_OUT(a1_post),
    .AUX2_POST_OUT(a2_post), .REF_DIVIDE_OUT(r_div), .MAIN_POWER_OUT(m_pwr),
    .AUX1_POWER_OUT(a1_pwr), .AUX2_POWER_OUT(a2_pwr), .LOCK_SEL_OUT(lock),
    .TEST_FIELD_OUT(test), .REF_TICK_OUT(tick), .MAIN_PD_REF_OUT(m_pd),
    .AUX1_PD_REF_OUT(a1_pd), .AUX2_PD_REF_OUT(a2_pd), .MAIN_SPEEDUP_OUT(m_spd),
    .AUX1_SPEEDUP_OUT(a1_spd), .AUX2_SPEEDUP_OUT(a2_spd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Oscillator at one eighth of the system rate; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) osc <= ~osc;
    if (cyc == 15000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Pulses counted only once an interval is already running
  task automatic measure(output int nm, n1, n2);
    logic pm, p1, p2, seen;
    {nm, n1, n2} = '0;
    {pm, p1, p2, seen} = '0;
    for (int i = 0; i < 1500; i++) begin
      @(posedge clk);
      nm += pm && m_spd && m_pd;
      n1 += p1 && a1_spd && a1_pd;
      n2 += p2 && a2_spd && a2_pd;
      if (seen && !(m_spd || a1_spd || a2_spd)) break;
      seen = seen || m_spd || a1_spd || a2_spd;
      {pm, p1, p2} = {m_spd, a1_spd, a2_spd};
    end
  endtask
  // Postscaled pulses over the next sixteen reference ticks
  task automatic count_pd(output int cm, c1, c2, nc);
    int nt;
    {cm, c1, c2, nc, nt} = '0;
    for (int i = 0; i < 100 && !tick; i++) @(posedge clk);
    while (nt < 16 && nc < 1000) begin
      @(posedge clk);
      nc++;
      cm += m_pd;
      c1 += a1_pd;
      c2 += a2_pd;
      nt += tick;
    end
  endtask
  // Out of reset nothing runs and the reference divider is one
  task automatic t_reset;
    chk(r_div, 16'd1);
    chk({m_pwr, a1_pwr, a2_pwr, m_spd, a1_spd, a2_spd}, 16'd0);
  endtask
  // Shifting alone is inert; auxiliary words apply by address
  task automatic t_aux;
    i_host.send_word({2'h1, 6'd3, 2'h2, 11'd6, 3'd5}, 1'b0);
    chk(a1_div, 16'd0);
    i_host.send_word({2'h1, 6'd3, 2'h2, 11'd6, 3'd5}, 1'b1);
    chk(a1_div, 16'd53);
    chk({a1_ctg, m_rat}, 16'h2);
    i_host.send_word({2'h2, 2'h2, 2'h1, 2'h3, 2'h1, 11'd7, 3'd7}, 1'b1);
    chk(a2_div, 16'd63);
    chk({a2_ctg, a_rat, m_post, a1_post, a2_post}, 16'h176);
    chk(a1_div, 16'd53);
    chk(m_div, 16'd0);
  endtask
  // Enables rising start both auxiliary intervals on their own counters
  task automatic t_device;
    int nm, n1, n2;
    i_host.send_word({2'h3, 6'h2a, 2'h1, 3'h7, 11'd3}, 1'b1);
    measure(nm, n1, n2);
    chk(16'(n1), 16'd6);
    chk(16'(n2), 16'd6);
    chk(16'(nm), 16'd0);
    chk(r_div, 16'd3);
    chk({test, lock, m_pwr, a1_pwr, a2_pwr}, {5'h0, 6'h2a, 2'h1, 3'h7});
  endtask
  // All postscaler codes, reference period three oscillator periods
  task automatic t_post;
    int cm, c1, c2, nc;
    count_pd(cm, c1, c2, nc);
    chk(16'(nc), 16'd384);
    chk({8'(cm), 4'(c1), 4'(c2)}, 16'h0284);
    i_host.send_word({2'h2, 2'h0, 2'h3, 2'h0, 2'h1, 11'd7, 3'd7}, 1'b1);
    count_pd(cm, c1, c2, nc);
    count_pd(cm, c1, c2, nc);
    chk({8'(cm), 8'(c1)}, 16'h1002);
    chk(16'(c2), 16'd16);
  endtask
  // Main word applies on a tick and runs twice its duration
  task automatic t_main(input logic [5:0] c, input logic [10:0] b, input logic [4:0] a);
    int nm, n1, n2;
    i_host.send_word({2'h0, c, b, a}, 1'b1);
    measure(nm, n1, n2);
    chk(16'(nm), {9'h0, c, 1'b0});
    chk(16'(n1 + n2), 16'd0);
    chk(m_div, 16'(32 * b + a));
    chk(m_ctg, b >= 11'd31);
  endtask
  // Re-sent enables start nothing; cycling one loop restarts only it
  task automatic t_redev;
    int nm, n1, n2;
    i_host.send_word({2'h3, 6'h2a, 2'h1, 3'h7, 11'd3}, 1'b1);
    measure(nm, n1, n2);
    chk(16'(nm + n1 + n2), 16'd0);
    i_host.send_word({2'h3, 6'h2a, 2'h1, 3'h5, 11'd3}, 1'b1);
    for (int i = 0; i < 40 && a1_pwr !== 1'b0; i++) @(posedge clk);
    chk({a1_pwr, a2_pwr}, 16'd1);
    i_host.send_word({2'h3, 6'h2a, 2'h1, 3'h7, 11'd3}, 1'b1);
    measure(nm, n1, n2);
    chk(16'(n1), 16'd6);
    chk(16'(nm + n2), 16'd0);
  endtask

  // Main sequence in full programming order
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_aux();
    t_device();
    t_post();
    t_main(6'd2, 11'd31, 5'd31);
    t_main(6'd1, 11'd30, 5'd7);
    t_redev();
    stop_test();
  end
endmodule
`default_nettype wire
